// ---- core/combined_ci_pkg.sv ----
// constants shared by the combined custom instruction unit
package combined_ci_pkg;
  localparam int DATA_W   = 32;
  localparam int SEL_W    = 2;
  localparam int NUM_FN   = 4;
  // fixed latency of every merged function before the output mux stage
  localparam int FN_LAT   = 2;
  // extra cycle added by the registered output multiplexer
  localparam int MUX_LAT  = 1;
  localparam logic [SEL_W-1:0] SEL_ADD = 2'h0;
  localparam logic [SEL_W-1:0] SEL_XOR = 2'h1;
  localparam logic [SEL_W-1:0] SEL_MUL = 2'h2;
  localparam logic [SEL_W-1:0] SEL_ROT = 2'h3;
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
endpackage

// ---- core/start_delay_chain.sv ----
// shift chain that turns a start pulse into a done pulse after a fixed latency
`timescale 1ns/1ps
module start_delay_chain #(
  parameter int LAT = 2
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // pulses
  input  wire logic start_i,
  output logic      done_o
);
  logic [LAT-1:0] chain_q;

  // start delayed by latency
  // split so a one-deep chain never names an empty slice
  if (LAT == 1) begin : g_one
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        chain_q <= '0;
      end else begin
        chain_q <= start_i;
      end
    end
  end else begin : g_many
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        chain_q <= '0;
      end else begin
        chain_q <= {chain_q[LAT-2:0], start_i};
      end
    end
  end

  assign done_o = chain_q[LAT-1];
endmodule

// ---- core/combined_custom_instruction.sv ----
// combined custom instruction: several fixed-latency functions behind one port
// Behaviour
// - at most two operands per operation, exactly one result returned
// - result is 32 bits; processor's own result mux is outside
// - selector bits choose the function via an internal multiplexer
// - internal output mux is registered; latency includes that stage
// - all merged functions share identical latency behaviour
// - functions are fixed latency or signal completion by done
// - start delayed per function by its latency, done is the registered OR of dones
`timescale 1ns/1ps
module combined_custom_instruction #(
  parameter int FN_LAT = combined_ci_pkg::FN_LAT
) (
  // clock and reset
  input  wire logic                                mclk_i,
  input  wire logic                                rst_i,
  // operation request
  input  wire logic                                start_i,
  input  wire logic [combined_ci_pkg::SEL_W-1:0]   sel_i,
  input  wire logic [combined_ci_pkg::DATA_W-1:0]  opa_i,
  input  wire logic [combined_ci_pkg::DATA_W-1:0]  opb_i,
  // completion
  output logic                                     done_o,
  output logic [combined_ci_pkg::DATA_W-1:0]       result_o
);
  localparam int NF = combined_ci_pkg::NUM_FN;
  localparam int DW = combined_ci_pkg::DATA_W;
  // done_o trails the take edge by the chain plus the mux stage
  localparam int DONE_LAT = FN_LAT + combined_ci_pkg::MUX_LAT;

  // per-function stage registers, FN_LAT deep
  // every function runs each cycle: cheaper than gating, costs some power
  // only the chain of the selected function fires, so the mux never sees stale data
  logic [DW-1:0]                         stage_q [NF][FN_LAT];
  logic [combined_ci_pkg::SEL_W-1:0]     sel_pipe_q [FN_LAT];
  logic [NF-1:0]                         fn_start;
  logic [NF-1:0]                         fn_done;
  logic [DW-1:0]                         fn_res [NF];
  logic [2*DW-1:0]                       prod;
  logic                                  any_done;

  assign prod = opa_i * opb_i;

  always_comb begin
    fn_res[0] = opa_i + opb_i;
    fn_res[1] = opa_i ^ opb_i;
    fn_res[2] = prod[DW-1:0];
    fn_res[3] = (opa_i << opb_i[4:0]) | (opa_i >> (6'h20 - {1'b0, opb_i[4:0]}));
  end

  // only the selected function is started
  always_comb begin
    for (int i = 0; i < NF; i++) begin
      fn_start[i] = start_i && (sel_i == i[combined_ci_pkg::SEL_W-1:0]);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NF; i++) begin
        for (int s = 0; s < FN_LAT; s++) begin
          stage_q[i][s] <= '0;
        end
      end
    end else begin
      for (int i = 0; i < NF; i++) begin
        stage_q[i][0] <= fn_res[i];
        for (int s = 1; s < FN_LAT; s++) begin
          stage_q[i][s] <= stage_q[i][s-1];
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int s = 0; s < FN_LAT; s++) begin
        sel_pipe_q[s] <= '0;
      end
    end else begin
      sel_pipe_q[0] <= sel_i;
      for (int s = 1; s < FN_LAT; s++) begin
        sel_pipe_q[s] <= sel_pipe_q[s-1];
      end
    end
  end

  for (genvar g = 0; g < NF; g++) begin : g_chain
    start_delay_chain #(
      .LAT (FN_LAT)
    ) u_chain (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .start_i (fn_start[g]),
      .done_o  (fn_done[g])
    );
  end

  assign any_done = |fn_done;

  // registered mux keeps the processor path short; adds one cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      result_o <= combined_ci_pkg::RESULT_RST;
    end else if (any_done) begin
      result_o <= stage_q[sel_pipe_q[FN_LAT-1]][FN_LAT-1];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= any_done;
    end
  end

  // latency, done and result checks
  sequence s_start;
    start_i;
  endsequence

  sequence s_done_at_lat;
    ##DONE_LAT done_o;
  endsequence

  property p_done_latency;
    @(posedge mclk_i) disable iff (rst_i)
    s_start |-> s_done_at_lat;
  endproperty
  a_done_latency: assert property (p_done_latency)
    else $error("done not seen at fixed latency");

  property p_done_pulse;
    @(posedge mclk_i) disable iff (rst_i)
    done_o |=> !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done held longer than one cycle");

  property p_done_cause;
    @(posedge mclk_i) disable iff (rst_i)
    done_o |-> $past(start_i, DONE_LAT);
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("done without start");

  property p_add_result;
    @(posedge mclk_i) disable iff (rst_i)
    (start_i && sel_i == combined_ci_pkg::SEL_ADD) |->
      ##DONE_LAT (result_o == $past(fn_res[0], DONE_LAT));
  endproperty
  a_add_result: assert property (p_add_result)
    else $error("add result wrong");

  property p_xor_result;
    @(posedge mclk_i) disable iff (rst_i)
    (start_i && sel_i == combined_ci_pkg::SEL_XOR) |->
      ##DONE_LAT (result_o == $past(fn_res[1], DONE_LAT));
  endproperty
  a_xor_result: assert property (p_xor_result)
    else $error("xor result wrong");

  property p_mul_result;
    @(posedge mclk_i) disable iff (rst_i)
    (start_i && sel_i == combined_ci_pkg::SEL_MUL) |->
      ##DONE_LAT (result_o == $past(fn_res[2], DONE_LAT));
  endproperty
  a_mul_result: assert property (p_mul_result)
    else $error("mul result wrong");

  property p_result_hold;
    @(posedge mclk_i) disable iff (rst_i)
    !any_done |=> $stable(result_o);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without done");

  property p_one_done;
    @(posedge mclk_i) disable iff (rst_i)
    $onehot0(fn_done);
  endproperty
  a_one_done: assert property (p_one_done)
    else $error("several function dones at once");

  // stalled processor means dones are at least one operation apart
  property p_done_spacing;
    @(posedge mclk_i) disable iff (rst_i)
    any_done |=> !any_done [*2];
  endproperty
  a_done_spacing: assert property (p_done_spacing)
    else $error("function dones closer than one operation");

  property p_rot_result;
    @(posedge mclk_i) disable iff (rst_i)
    (start_i && sel_i == combined_ci_pkg::SEL_ROT) |->
      ##DONE_LAT (result_o == $past(fn_res[3], DONE_LAT));
  endproperty
  a_rot_result: assert property (p_rot_result)
    else $error("rotate result wrong");

  property p_done_from_chain;
    @(posedge mclk_i) disable iff (rst_i)
    done_o == $past(any_done);
  endproperty
  a_done_from_chain: assert property (p_done_from_chain)
    else $error("done not a registered copy of the chain outputs");

  property p_chain_delay;
    @(posedge mclk_i) disable iff (rst_i)
    start_i |-> ##FN_LAT any_done;
  endproperty
  a_chain_delay: assert property (p_chain_delay)
    else $error("chain done not at function latency");

  property p_done_sel;
    @(posedge mclk_i) disable iff (rst_i)
    any_done |-> fn_done[sel_pipe_q[FN_LAT-1]];
  endproperty
  a_done_sel: assert property (p_done_sel)
    else $error("done chain does not match mux select");
endmodule

// ---- testbench/ci_host.sv ----
// processor-side model: issues one operation, then stalls
`timescale 1ns/1ps
module ci_host (
  // clock
  input  wire logic        mclk_i,
  // request
  output logic             start_o,
  output logic [1:0]       sel_o,
  output logic [31:0]      opa_o,
  output logic [31:0]      opb_o,
  // completion
  input  wire logic        done_i,
  input  wire logic [31:0] result_i
);
  initial begin
    start_o = 1'b0;
    sel_o = 2'h0;
    opa_o = 32'h0;
    opb_o = 32'h0;
  end
  task automatic run(input logic [1:0] s, input logic [31:0] a, input logic [31:0] b,
                     output logic [31:0] r, output int lat);
    @(negedge mclk_i);
    start_o = 1'b1;
    sel_o = s;
    opa_o = a;
    opb_o = b;
    @(negedge mclk_i);
    // operands are not held after the take edge
    start_o = 1'b0;
    sel_o = ~s;
    opa_o = ~a;
    opb_o = ~b;
    lat = 1;
    while (done_i !== 1'b1 && lat < 20) begin
      @(negedge mclk_i);
      lat++;
    end
    r = result_i;
  endtask
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the combined custom instruction unit
`timescale 1ns/1ps
module testbench;
  logic        mclk_i;
  logic        rst_i;
  logic        start_i;
  logic [1:0]  sel_i;
  logic [31:0] opa_i;
  logic [31:0] opb_i;
  logic        done_o;
  logic [31:0] result_o;
  logic [31:0] rng;
  logic [31:0] got;
  logic [31:0] exp_q[$];
  int          lat;
  int          num_errors;
  int          comparisons;

  initial mclk_i = 1'b0;
  always #12.5 mclk_i = ~mclk_i;

  combined_custom_instruction uut (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(start_i),
    .sel_i(sel_i), .opa_i(opa_i), .opb_i(opb_i), .done_o(done_o), .result_o(result_o));
  ci_host host (.mclk_i(mclk_i), .start_o(start_i), .sel_o(sel_i), .opa_o(opa_i),
    .opb_o(opb_i), .done_i(done_o), .result_i(result_o));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // reference functions, one per selector code
  function automatic logic [31:0] model(input int s, input longint a, input longint b);
    int n;
    n = int'(b % 32);
    case (s)
      0: return 32'(a + b);
      1: return 32'(a ^ b);
      2: return 32'(a * b);
      default: return 32'((a << n) | (a >> (32 - n)));
    endcase
  endfunction

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      $display("ERROR %0t: got %h expected %h", $time, g, e);
      num_errors++;
    end
  endtask

  task automatic stop_test;
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic op(input logic [1:0] s, input logic [31:0] a, input logic [31:0] b);
    exp_q.push_back(model(s, a, b));
    host.run(s, a, b, got, lat);
    check(32'(lat), 32'(combined_ci_pkg::FN_LAT + combined_ci_pkg::MUX_LAT));
    if (lat >= 20)
      stop_test();
    check(got, exp_q.pop_front());
    @(negedge mclk_i);
    check({31'h0, done_o}, 32'h0);
    check(result_o, got);
  endtask

  initial begin
    num_errors = 0;
    comparisons = 0;
    rng = 32'h0000_A69F;
    rst_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    check(result_o, combined_ci_pkg::RESULT_RST);
    rst_i = 1'b0;
    for (int i = 0; i < 48; i++) begin
      rng = xorshift(rng);
      got = xorshift(rng);
      if (i < 8)
        op(2'(i), 32'hFFFF_FFFF, 32'(i * 31));
      else
        op(2'(i), rng, got);
    end
    @(negedge mclk_i);
    rst_i = 1'b1;
    @(negedge mclk_i);
    check(result_o, combined_ci_pkg::RESULT_RST);
    rst_i = 1'b0;
    op(combined_ci_pkg::SEL_MUL, 32'h8000_0001, 32'h0000_0003);
    op(combined_ci_pkg::SEL_ROT, 32'h1234_5678, 32'h0000_0020);
    stop_test();
  end
endmodule
